// >>> common/uart_shadow_pkg.sv
package uart_shadow_pkg;
   // Bus and data widths
   localparam int BUS_W = 32;
   localparam int CHAR_W = 8;
   localparam int FIFO_DEPTH_DEF = 16;
   // Shadow window: sixteen aliased words, index 4 at 0x50001140
   localparam logic [31:0] SHADOW_BASE = 32'h5000_1130;
   localparam logic [31:0] SHADOW_LAST = 32'h5000_116C;
   localparam logic [31:0] SHADOW_4_ADDR = 32'h5000_1140;
   // Control, status and interrupt registers
   localparam logic [31:0] FIFO_CTRL_ADDR = 32'h5000_1108;
   localparam logic [31:0] LINE_STAT_ADDR = 32'h5000_1114;
   localparam logic [31:0] IRQ_STAT_ADDR = 32'h5000_1180;
   localparam logic [31:0] IRQ_EN_ADDR = 32'h5000_1184;
   localparam logic [31:0] IRQ_CLR_ADDR = 32'h5000_1188;
   // Field positions
   localparam int FIFO_EN_BIT = 0;
   localparam int RX_READY_BIT = 0;
   localparam int OVERRUN_BIT = 1;
   localparam int TX_EMPTY_BIT = 5;
   // Interrupt event bits
   localparam int EV_RX = 0;
   localparam int EV_OVR = 1;
   localparam int EV_TXE = 2;
   localparam int EV_W = 3;
   // Reset values
   localparam logic [15:0] SHADOW_RESET = 16'h0000;
   localparam logic FIFO_EN_RESET = 1'b0;
   localparam logic [EV_W-1:0] IRQ_EN_RESET = 3'h0;

   typedef struct packed {
      logic valid;
      logic [CHAR_W-1:0] data;
   } char_t;

   typedef struct packed {
      logic [BUS_W-1:0] addr;
      logic [BUS_W-1:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   typedef enum logic [1:0] {
      HOLD_EMPTY = 2'b01,
      HOLD_FULL = 2'b10
   } hold_state_t;
endpackage

// >>> hw/byte_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module byte_fifo
   import uart_shadow_pkg::*;
#(
   parameter int WIDTH = CHAR_W, // Entry width
   parameter int DEPTH = FIFO_DEPTH_DEF, // Entries, power of two
   parameter int CW = $clog2(DEPTH + 1) // Count width
) (
   input wire logic clk, // Clock
   input wire logic reset, // Async, active high
   input wire logic flush, // Empty the FIFO
   input wire logic push, // Write request
   input wire logic [WIDTH-1:0] din, // Write data
   input wire logic pop, // Read request
   output logic [WIDTH-1:0] dout, // Head entry
   output logic [CW-1:0] count, // Entries held
   output logic full, // No room
   output logic empty // Nothing held
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("byte_fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_q, rd_ptr_q;
   logic [CW-1:0] count_q;
   logic push_ok, pop_ok;

   // A push into a full FIFO only lands if a pop frees a slot
   assign empty = (count_q == '0);
   assign full = (count_q == CW'(DEPTH));
   assign pop_ok = pop & ~empty;
   assign push_ok = push & (~full | pop_ok);
   assign dout = mem[rd_ptr_q];
   assign count = count_q;

   // Storage
   always_ff @(posedge clk) begin
      if (push_ok) begin
         mem[wr_ptr_q] <= din;
      end
   end

   // Pointers and fill level
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else if (flush) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push_ok) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop_ok) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         if (push_ok && !pop_ok) begin
            count_q <= count_q + 1'b1;
         end else if (pop_ok && !push_ok) begin
            count_q <= count_q - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> hw/event_irq.sv
`timescale 1ns/100ps
`default_nettype none
module event_irq
   import uart_shadow_pkg::*;
#(
   parameter int N = EV_W // Event count
) (
   input wire logic clk, // Clock
   input wire logic reset, // Async, active high
   input wire logic [N-1:0] set, // Event pulses
   input wire logic clr_wr, // Clear register write
   input wire logic [N-1:0] clr, // Bits to clear
   input wire logic en_wr, // Enable register write
   input wire logic [N-1:0] en_in, // New enable mask
   output logic [N-1:0] status, // Sticky status
   output logic [N-1:0] enable, // Enable mask
   output logic irq // Level interrupt
);
   logic [N-1:0] status_q, enable_q;

   // Sticky status, a new event beats a clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         status_q <= '0;
      end else if (clr_wr) begin
         status_q <= set | (status_q & ~clr);
      end else begin
         status_q <= set | status_q;
      end
   end

   // Enable mask
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         enable_q <= N'(IRQ_EN_RESET);
      end else if (en_wr) begin
         enable_q <= en_in;
      end
   end

   assign status = status_q;
   assign enable = enable_q;
   assign irq = |(status_q & enable_q);
endmodule
`default_nettype wire

// >>> hw/uart_shadow_rx_tx_buffer.sv
`timescale 1ns/100ps
`default_nettype none
module uart_shadow_rx_tx_buffer
   import uart_shadow_pkg::*;
#(
   parameter int RX_DEPTH = FIFO_DEPTH_DEF, // Receive FIFO entries
   parameter int TX_DEPTH = FIFO_DEPTH_DEF // Transmit FIFO entries
) (
   input wire logic clk, // 50 MHz clock
   input wire logic reset, // Async, active high
   input wire bus_req_t req, // Register bus request
   output logic [BUS_W-1:0] rdata, // Read data, cycle after read
   input wire char_t rx_in, // Received char, one-cycle valid
   output var char_t tx_out, // Char offered to transmitter
   input wire logic tx_ready, // Transmitter takes tx_out
   output logic irq // Level interrupt
);
   localparam int RX_CW = $clog2(RX_DEPTH + 1);
   localparam int TX_CW = $clog2(TX_DEPTH + 1);

   logic sh_hit, stat_hit, ctrl_hit, ist_hit, ien_hit, icl_hit;
   logic shadow_rd, shadow_wr, stat_rd, ctrl_wr;
   logic fifo_en_q, mode_flush;
   logic rx_push, rx_pop, rx_full, rx_empty, rx_drop;
   logic [CHAR_W-1:0] rx_head, rhr_q;
   logic [RX_CW-1:0] rx_count;
   logic rhr_valid_q, overrun_ev, overrun_q, data_ready;
   logic tx_push, tx_pop, tx_full, tx_empty, hold_wr, xmit_empty, xmit_empty_q;
   logic [CHAR_W-1:0] tx_head, hold_byte_q;
   logic [TX_CW-1:0] tx_count;
   hold_state_t hold_q, hold_d;
   logic [EV_W-1:0] events, irq_status, irq_enable;
   logic [BUS_W-1:0] rdata_d;

   // Address decode, all sixteen shadow words alias one buffer
   always_comb begin
      sh_hit = 1'b0;
      stat_hit = 1'b0;
      ctrl_hit = 1'b0;
      ist_hit = 1'b0;
      ien_hit = 1'b0;
      icl_hit = 1'b0;
      if (req.addr >= SHADOW_BASE && req.addr <= SHADOW_LAST
          && req.addr[1:0] == 2'h0) begin
         sh_hit = 1'b1;
      end else if (req.addr == LINE_STAT_ADDR) begin
         stat_hit = 1'b1;
      end else if (req.addr == FIFO_CTRL_ADDR) begin
         ctrl_hit = 1'b1;
      end else if (req.addr == IRQ_STAT_ADDR) begin
         ist_hit = 1'b1;
      end else if (req.addr == IRQ_EN_ADDR) begin
         ien_hit = 1'b1;
      end else if (req.addr == IRQ_CLR_ADDR) begin
         icl_hit = 1'b1;
      end
   end

   assign shadow_rd = req.rd & sh_hit;
   assign shadow_wr = req.wr & sh_hit;
   assign stat_rd = req.rd & stat_hit;
   assign ctrl_wr = req.wr & ctrl_hit;

   // FIFO enable; changing it empties both paths
   assign mode_flush = ctrl_wr && (req.wdata[FIFO_EN_BIT] != fifo_en_q);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fifo_en_q <= FIFO_EN_RESET;
      end else if (ctrl_wr) begin
         fifo_en_q <= req.wdata[FIFO_EN_BIT];
      end
   end

   // Receive FIFO, a full FIFO keeps its contents
   assign rx_pop = shadow_rd & fifo_en_q;
   assign rx_push = rx_in.valid & fifo_en_q & (~rx_full | rx_pop);
   assign rx_drop = rx_in.valid & fifo_en_q & rx_full & ~rx_pop;

   byte_fifo #(
      .WIDTH(CHAR_W),
      .DEPTH(RX_DEPTH),
      .CW(RX_CW)
   ) rx_fifo (
      .clk(clk),
      .reset(reset),
      .flush(mode_flush),
      .push(rx_push),
      .din(rx_in.data),
      .pop(rx_pop),
      .dout(rx_head),
      .count(rx_count),
      .full(rx_full),
      .empty(rx_empty)
   );

   // Single receive holding byte when FIFOs are off
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rhr_q <= SHADOW_RESET[CHAR_W-1:0];
         rhr_valid_q <= 1'b0;
      end else if (mode_flush) begin
         rhr_valid_q <= 1'b0;
      end else if (rx_in.valid && !fifo_en_q) begin
         rhr_q <= rx_in.data;
         rhr_valid_q <= 1'b1;
      end else if (shadow_rd && !fifo_en_q) begin
         rhr_valid_q <= 1'b0;
      end
   end

   // Overrun: unread byte overwritten, or full FIFO drops one
   assign overrun_ev = rx_drop
      | (rx_in.valid & ~fifo_en_q & rhr_valid_q & ~shadow_rd);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         overrun_q <= 1'b0;
      end else if (overrun_ev) begin
         overrun_q <= 1'b1;
      end else if (stat_rd) begin
         overrun_q <= 1'b0;
      end
   end

   assign data_ready = fifo_en_q ? ~rx_empty : rhr_valid_q;

   // Transmit FIFO, writes to a full FIFO are lost unless tx_ready pops a byte in the same cycle
   assign tx_push = shadow_wr & fifo_en_q;
   assign tx_pop = fifo_en_q & tx_ready;

   byte_fifo #(
      .WIDTH(CHAR_W),
      .DEPTH(TX_DEPTH),
      .CW(TX_CW)
   ) tx_fifo (
      .clk(clk),
      .reset(reset),
      .flush(mode_flush),
      .push(tx_push),
      .din(req.wdata[CHAR_W-1:0]),
      .pop(tx_pop),
      .dout(tx_head),
      .count(tx_count),
      .full(tx_full),
      .empty(tx_empty)
   );

   // Transmit holding byte, later writes overwrite it
   assign hold_wr = shadow_wr & ~fifo_en_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hold_byte_q <= SHADOW_RESET[CHAR_W-1:0];
      end else if (hold_wr) begin
         hold_byte_q <= req.wdata[CHAR_W-1:0];
      end
   end

   // Holding state: a write fills it, the transmitter empties it
   always_comb begin
      hold_d = hold_q;
      case (hold_q)
         HOLD_EMPTY: begin
            if (hold_wr) begin
               hold_d = HOLD_FULL;
            end
         end
         HOLD_FULL: begin
            if (!hold_wr && tx_ready) begin
               hold_d = HOLD_EMPTY;
            end
         end
         default: hold_d = HOLD_EMPTY;
      endcase
      if (mode_flush) begin
         hold_d = HOLD_EMPTY;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hold_q <= HOLD_EMPTY;
      end else begin
         hold_q <= hold_d;
      end
   end

   assign xmit_empty = fifo_en_q ? tx_empty : (hold_q == HOLD_EMPTY);

   // Offer to the transmitter
   always_comb begin
      tx_out.valid = fifo_en_q ? ~tx_empty : (hold_q == HOLD_FULL);
      tx_out.data = fifo_en_q ? tx_head : hold_byte_q;
   end

   // Holding-empty rise detect for the interrupt
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         xmit_empty_q <= 1'b1;
      end else begin
         xmit_empty_q <= xmit_empty;
      end
   end

   // Interrupt events
   always_comb begin
      events = '0;
      events[EV_RX] = rx_push | (rx_in.valid & ~fifo_en_q);
      events[EV_OVR] = overrun_ev;
      events[EV_TXE] = xmit_empty & ~xmit_empty_q;
   end

   event_irq #(
      .N(EV_W)
   ) irq_ctl (
      .clk(clk),
      .reset(reset),
      .set(events),
      .clr_wr(req.wr & icl_hit),
      .clr(req.wdata[EV_W-1:0]),
      .en_wr(req.wr & ien_hit),
      .en_in(req.wdata[EV_W-1:0]),
      .status(irq_status),
      .enable(irq_enable),
      .irq(irq)
   );

   // Read data mux, unmapped and write-only words read zero
   always_comb begin
      rdata_d = '0;
      if (sh_hit) begin
         rdata_d[CHAR_W-1:0] = fifo_en_q ? rx_head : rhr_q;
      end else if (stat_hit) begin
         rdata_d[RX_READY_BIT] = data_ready;
         rdata_d[OVERRUN_BIT] = overrun_q;
         rdata_d[TX_EMPTY_BIT] = xmit_empty;
      end else if (ctrl_hit) begin
         rdata_d[FIFO_EN_BIT] = fifo_en_q;
      end else if (ist_hit) begin
         rdata_d[EV_W-1:0] = irq_status;
      end else if (ien_hit) begin
         rdata_d[EV_W-1:0] = irq_enable;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata <= '0;
      end else if (req.rd) begin
         rdata <= rdata_d;
      end else begin
         rdata <= '0;
      end
   end

   // Checks
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_shadow_read;
      req.rd && sh_hit;
   endsequence

   sequence s_shadow_write;
      req.wr && sh_hit;
   endsequence

   sequence s_fifo_pop;
      s_shadow_read ##0 fifo_en_q && !rx_empty && !rx_in.valid && !ctrl_wr;
   endsequence

   a_alias_pop: assert property (
      s_fifo_pop |=> rx_count == $past(rx_count) - 1'b1)
      else $error("shadow read did not pop receive FIFO");

   a_rx_byte_read: assert property (
      s_shadow_read ##0 !fifo_en_q |=> rdata[CHAR_W-1:0] == $past(rhr_q))
      else $error("shadow read lost holding byte");

   a_ready_flag: assert property (
      rx_in.valid && !req.rd && !ctrl_wr |=> data_ready)
      else $error("data ready not set by arrival");

   a_overrun_nofifo: assert property (
      rx_in.valid && !fifo_en_q && rhr_valid_q && !req.rd && !ctrl_wr
      |=> overrun_q && rhr_q == $past(rx_in.data))
      else $error("overwrite without overrun");

   a_head_read: assert property (
      s_shadow_read ##0 fifo_en_q && !rx_empty
      |=> rdata[CHAR_W-1:0] == $past(rx_head))
      else $error("shadow read not FIFO head");

   a_rx_full_keep: assert property (
      rx_in.valid && fifo_en_q && rx_full && !req.rd && !ctrl_wr
      |=> rx_full && overrun_q && rx_head == $past(rx_head))
      else $error("full receive FIFO changed on arrival");

   a_tx_queue: assert property (
      s_shadow_write ##0 !fifo_en_q && !ctrl_wr
      |=> tx_out.valid && tx_out.data == $past(req.wdata[CHAR_W-1:0]))
      else $error("written byte not offered");

   a_empty_clear: assert property (
      s_shadow_write ##0 !fifo_en_q && xmit_empty && !ctrl_wr
      |=> !xmit_empty ##1 (!xmit_empty || $past(tx_ready) || $past(ctrl_wr)))
      else $error("holding empty not cleared by write");

   a_tx_fill: assert property (
      s_shadow_write ##0 fifo_en_q && !tx_full && !tx_ready && !ctrl_wr
      |=> tx_count == $past(tx_count) + 1'b1)
      else $error("transmit FIFO did not take byte");

   a_tx_full_drop: assert property (
      s_shadow_write ##0 fifo_en_q && tx_full && !tx_ready && !ctrl_wr
      |=> tx_full && tx_head == $past(tx_head))
      else $error("full transmit FIFO changed on write");

   a_high_zero: assert property (
      s_shadow_read |=> rdata[BUS_W-1:CHAR_W] == '0)
      else $error("reserved shadow bits not zero");
endmodule
`default_nettype wire

// >>> verif/serial_peer.sv
`timescale 1ns/100ps
`default_nettype none
module serial_peer
   import uart_shadow_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic reset, // Async, active high
   input wire char_t tx_out, // Char offered by block
   input wire logic stall, // Hold off taking chars
   output var char_t rx_in, // Char delivered to block
   output logic tx_ready // Take offered char
);
   logic [CHAR_W-1:0] taken_q[$];

   // Ready is the inverse of the stall request
   assign tx_ready = !stall;

   // Record every char taken off the transmit side
   always @(posedge clk) begin
      if (!reset && tx_out.valid && tx_ready) begin
         taken_q.push_back(tx_out.data);
      end
   end

   // One-cycle strobe, data scrambled once released
   task automatic send_char(input logic [CHAR_W-1:0] b);
      @(posedge clk);
      rx_in <= '{valid: 1'b1, data: b};
      @(posedge clk);
      rx_in <= '{valid: 1'b0, data: ~b};
   endtask

   // Idle line at time zero
   initial begin
      rx_in = '0;
   end
endmodule
`default_nettype wire

// >>> verif/test_uart_shadow_rx_tx_buffer.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) \
   checks_done++; \
   if ((got) !== (exp)) begin \
      failures++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
   end
module test_uart_shadow_rx_tx_buffer
   import uart_shadow_pkg::*;
;
   localparam int DEPTH = 4;
   logic clk = 1'b0;
   logic reset = 1'b1;
   bus_req_t req = '0;
   logic [BUS_W-1:0] rdata;
   char_t rx_in;
   char_t tx_out;
   logic tx_ready;
   logic irq;
   logic stall = 1'b0;
   int failures = 0;
   int checks_done = 0;

   // 50 MHz clock
   always #10 clk = ~clk;

   uart_shadow_rx_tx_buffer #(.RX_DEPTH(DEPTH), .TX_DEPTH(DEPTH)) dut (
      .clk(clk), .reset(reset), .req(req), .rdata(rdata), .rx_in(rx_in),
      .tx_out(tx_out), .tx_ready(tx_ready), .irq(irq));

   serial_peer peer (
      .clk(clk), .reset(reset), .tx_out(tx_out), .stall(stall), .rx_in(rx_in),
      .tx_ready(tx_ready));

   // One-cycle write strobe
   task automatic bus_wr(input logic [BUS_W-1:0] a, input logic [BUS_W-1:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask

   // One-cycle read strobe, data taken in the following cycle
   task automatic rd_chk(input logic [BUS_W-1:0] a, input logic [BUS_W-1:0] exp,
                         input string what);
      @(posedge clk);
      req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      `CHK(what, exp, rdata)
   endtask

   // Verdict and end of run
   task automatic tally_and_finish();
      $display("Checks %0d, errors %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Cut a hang short
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      tally_and_finish();
   end

   // Test sequence
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      #1 `CHK("tx valid after reset", 1'b0, tx_out.valid)
      rd_chk(SHADOW_4_ADDR, 32'h0, "shadow after reset");
      rd_chk(LINE_STAT_ADDR, 32'h20, "line status after reset");
      // Holding mode receive, aliases and overrun
      peer.send_char(8'hA5);
      rd_chk(LINE_STAT_ADDR, 32'h21, "data ready set");
      rd_chk(SHADOW_BASE, 32'hA5, "alias base read");
      rd_chk(LINE_STAT_ADDR, 32'h20, "data ready cleared");
      peer.send_char(8'h11);
      peer.send_char(8'h22);
      rd_chk(LINE_STAT_ADDR, 32'h23, "overrun flagged");
      rd_chk(SHADOW_LAST, 32'h22, "newest byte kept");
      rd_chk(LINE_STAT_ADDR, 32'h20, "overrun cleared");
      // Holding mode transmit, second write overwrites
      stall <= 1'b1;
      bus_wr(SHADOW_4_ADDR, 32'hFF3C);
      #1 `CHK("tx byte", 8'h3C, tx_out.data)
      rd_chk(LINE_STAT_ADDR, 32'h00, "holding full");
      bus_wr(SHADOW_4_ADDR, 32'h77);
      stall <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK("taken count", 1, peer.taken_q.size())
      `CHK("taken byte", 8'h77, peer.taken_q[0])
      rd_chk(LINE_STAT_ADDR, 32'h20, "holding empty again");
      // Interrupt status, enable and clear
      rd_chk(IRQ_STAT_ADDR, 32'h7, "sticky events");
      `CHK("irq masked", 1'b0, irq)
      bus_wr(IRQ_EN_ADDR, 32'h2);
      #1 `CHK("irq on overrun", 1'b1, irq)
      bus_wr(IRQ_CLR_ADDR, 32'h2);
      #1 `CHK("irq after clear", 1'b0, irq)
      rd_chk(IRQ_STAT_ADDR, 32'h5, "overrun status cleared");
      rd_chk(IRQ_EN_ADDR, 32'h2, "enable readback");
      rd_chk(IRQ_CLR_ADDR, 32'h0, "clear reads zero");
      bus_wr(32'h5000_1200, 32'hFF);
      rd_chk(32'h5000_1200, 32'h0, "unmapped read");
      // FIFO mode receive: fill past full, drain through aliases
      bus_wr(FIFO_CTRL_ADDR, 32'h1);
      rd_chk(FIFO_CTRL_ADDR, 32'h1, "fifo enabled");
      for (int i = 0; i <= DEPTH; i++) begin
         peer.send_char(8'(8'h80 + i));
      end
      rd_chk(LINE_STAT_ADDR, 32'h23, "rx fifo overrun");
      for (int i = 0; i < DEPTH; i++) begin
         rd_chk(SHADOW_BASE + 32'(4 * i), 32'h80 + 32'(i), "rx fifo head");
      end
      rd_chk(LINE_STAT_ADDR, 32'h20, "rx fifo drained");
      // FIFO mode transmit: check the empty flag is set, then fill regardless
      rd_chk(LINE_STAT_ADDR, 32'h20, "tx empty before fill");
      // Fill past full while stalled, then drain
      peer.taken_q.delete();
      stall <= 1'b1;
      for (int i = 0; i <= DEPTH; i++) begin
         bus_wr(SHADOW_4_ADDR, 32'hAB40 + 32'(i));
      end
      stall <= 1'b0;
      repeat (2 * DEPTH) @(posedge clk);
      `CHK("tx fifo count", DEPTH, peer.taken_q.size())
      for (int i = 0; i < DEPTH; i++) begin
         `CHK("tx fifo byte", 8'(8'h40 + i), peer.taken_q[i])
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
